// [shared/clc_pkg.sv]
// Purpose: Constants and types for the configurable logic cell
// Assumes: AHB-Lite register access, 32-bit data, one aligned word per register
// Notes: Configuration word fields are placed by the offsets below
package clc_pkg;
  // Register byte offsets
  localparam logic [7:0] CLC_CFG_OFF = 8'h00;
  localparam logic [7:0] CLC_LUT_OFF = 8'h04;
  localparam logic [7:0] CLC_STAT_OFF = 8'h08;
  // Reset values
  localparam logic [31:0] CLC_CFG_RST = 32'h0000_0000;
  localparam logic [15:0] CLC_LUT_RST = 16'h0000;
  // Configuration field positions
  localparam int CLC_F_MODE = 0;
  localparam int CLC_F_FF = 2;
  localparam int CLC_F_BYP = 4;
  localparam int CLC_F_OUTA = 5;
  localparam int CLC_F_OUTB = 6;
  localparam int CLC_F_CASC_EN = 7;
  localparam int CLC_F_CASC_OR = 8;
  localparam int CLC_F_CLK_SRC = 9;
  localparam int CLC_F_CLR_SRC = 11;
  localparam int CLC_F_CTL = 13;
  localparam int CLC_F_POS = 16;
  localparam int CLC_F_FINAL = 20;
  // Chain geometry
  localparam logic [3:0] CLC_POS_FIRST = 4'h1;
  localparam logic [3:0] CLC_POS_LAST = 4'hA;
  // Cell cost of native and emulated control schemes
  localparam logic [2:0] CLC_COST_NATIVE = 3'h1;
  localparam logic [2:0] CLC_COST_EMUL = 3'h4;
  // Operating modes, storage types, signal sources, control schemes
  typedef enum logic [1:0] {CLC_NORMAL, CLC_ARITH, CLC_COUNTER, CLC_MODE_RSVD} clc_mode_t;
  typedef enum logic [1:0] {CLC_FF_D, CLC_FF_T, CLC_FF_JK, CLC_FF_SR} clc_ff_t;
  typedef enum logic [1:0] {CLC_SRC_GLOBAL, CLC_SRC_PIN, CLC_SRC_INTERNAL, CLC_SRC_OFF} clc_src_t;
  typedef enum logic [2:0] {
    CLC_CTL_CLR, CLC_CTL_PRE, CLC_CTL_PRE_CLR, CLC_CTL_ALOAD, CLC_CTL_PRE_LOAD
  } clc_ctl_t;
  // AHB-Lite encodings
  localparam logic [1:0] CLC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] CLC_HTRANS_SEQ = 2'h3;
  localparam logic CLC_HRESP_OKAY = 1'h0;
endpackage

// [hw/clc_cell.sv]
// Purpose: One configurable logic cell with lookup table, storage element and chains
// Assumes: All cell and group inputs synchronous to hclk; a cell clock event is a
//          cycle in which the selected tick source is high
// Notes: Configuration over AHB-Lite; zero wait states, always OKAY
// Functional notes
// - Storage element acts as D, T, JK, SR
// - Clock and clear sources are selectable
// - Bypass lets lookup result drive outputs
// - Two outputs, each lookup or register
// - Chains link cells 1 to 10, across groups
// - Carry in feeds lookup and onward chain
// - Group hops keep even or odd parity
// - n-bit adder uses n+1 cells
// - Adder register bypassed or accumulating
// - Exactly one of three modes active
// - Seven inputs routed by mode
// - Group-wide controls drive storage in every mode
// - Counter: two 3-input tables, load mux, clear gate
// - Sync clear or load beats cascade value
// - Sync clear beats sync load
// - Arithmetic mode gives registered and raw result
// - Native clear; other async controls cost four cells
// - Preset plus load state unknown after clear
// - Chip-wide clear overrides all register controls
// - Emulated preset registers, except preset plus load, preset on chip clear
// - Cascade combines neighbouring lookup results
//
// The placing of the registers and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/10ps
module clc_cell #(
  parameter bit GCLR_EN = 1'b1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [3:0] data_in,
  input wire logic carry_in,
  input wire logic cascade_in,
  input wire logic tick_global,
  input wire logic tick_pin,
  input wire logic tick_internal,
  input wire logic clr_global,
  input wire logic clr_pin,
  input wire logic clr_internal,
  input wire logic grp_apreset,
  input wire logic grp_aload,
  input wire logic grp_aload_data,
  input wire logic grp_sclr,
  input wire logic grp_sload,
  input wire logic grp_sload_data,
  input wire logic grp_ena,
  input wire logic global_register_clear_n,
  output logic out_a,
  output logic out_b,
  output logic carry_out,
  output logic carry_hop_out,
  output logic cascade_out,
  output logic cells_used_emul
);

  logic [31:0] cfg_r;
  logic [15:0] lut_r;
  logic q_r;
  logic q_unknown_r;
  logic q_nxt;
  logic unknown_nxt;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] hrdata_r;

  // Configuration decode
  wire clc_pkg::clc_mode_t mode_raw = clc_pkg::clc_mode_t'(cfg_r[clc_pkg::CLC_F_MODE +: 2]);
  wire clc_pkg::clc_ff_t ff_type = clc_pkg::clc_ff_t'(cfg_r[clc_pkg::CLC_F_FF +: 2]);
  wire clc_pkg::clc_src_t clk_src = clc_pkg::clc_src_t'(cfg_r[clc_pkg::CLC_F_CLK_SRC +: 2]);
  wire clc_pkg::clc_src_t clr_src = clc_pkg::clc_src_t'(cfg_r[clc_pkg::CLC_F_CLR_SRC +: 2]);
  wire [2:0] ctl_raw = cfg_r[clc_pkg::CLC_F_CTL +: 3];
  wire bypass = cfg_r[clc_pkg::CLC_F_BYP];
  wire outa_reg = cfg_r[clc_pkg::CLC_F_OUTA];
  wire outb_reg = cfg_r[clc_pkg::CLC_F_OUTB];
  wire casc_en = cfg_r[clc_pkg::CLC_F_CASC_EN];
  wire casc_or = cfg_r[clc_pkg::CLC_F_CASC_OR];
  wire [3:0] cell_pos = cfg_r[clc_pkg::CLC_F_POS +: 4];
  wire final_cell = cfg_r[clc_pkg::CLC_F_FINAL];

  // Reserved mode code falls back to normal so one mode is always in force
  wire clc_pkg::clc_mode_t mode =
    (mode_raw == clc_pkg::CLC_MODE_RSVD) ? clc_pkg::CLC_NORMAL : mode_raw;
  wire is_norm = (mode == clc_pkg::CLC_NORMAL);
  wire is_arith = (mode == clc_pkg::CLC_ARITH);
  wire is_cnt = (mode == clc_pkg::CLC_COUNTER);
  wire clc_pkg::clc_ctl_t ctl =
    (ctl_raw > 3'(clc_pkg::CLC_CTL_PRE_LOAD)) ? clc_pkg::CLC_CTL_CLR : clc_pkg::clc_ctl_t'(ctl_raw);

  // Lookup tables; low half = sum/count table, high half = carry table
  wire op_a = is_cnt ? q_r : data_in[0];
  wire op_b = is_cnt ? data_in[0] : data_in[1];
  wire [2:0] idx3 = {op_a, op_b, carry_in};
  wire lut_sum = lut_r[{1'b0, idx3}];
  wire lut_carry = lut_r[{1'b1, idx3}];
  wire lut_norm = lut_r[data_in];
  wire lut_res = is_norm ? lut_norm : lut_sum;

  // Final adder cell puts the incoming carry onto routing
  wire cell_val_raw = final_cell ? carry_in : lut_res;
  wire casc_comb = casc_or ? (cascade_in | cell_val_raw) : (cascade_in & cell_val_raw);
  wire cell_val = casc_en ? casc_comb : cell_val_raw;

  // Carry continues through normal cells, generated in arithmetic and counter cells
  wire carry_gen = is_norm ? carry_in : lut_carry;
  wire last_in_group = (cell_pos == clc_pkg::CLC_POS_LAST);
  assign carry_out = last_in_group ? 1'b0 : carry_gen;
  // Last cell hands carry to same-parity group two ahead
  assign carry_hop_out = last_in_group ? carry_gen : 1'b0;
  assign cascade_out = cell_val;

  // Source selection
  wire tick = (clk_src == clc_pkg::CLC_SRC_GLOBAL) ? tick_global :
              (clk_src == clc_pkg::CLC_SRC_PIN) ? tick_pin :
              (clk_src == clc_pkg::CLC_SRC_INTERNAL) ? tick_internal : 1'b0;
  wire aclr = (clr_src == clc_pkg::CLC_SRC_GLOBAL) ? clr_global :
              (clr_src == clc_pkg::CLC_SRC_PIN) ? clr_pin :
              (clr_src == clc_pkg::CLC_SRC_INTERNAL) ? clr_internal : 1'b0;

  // Storage element function
  wire k_in = data_in[3];
  wire ff_val = (ff_type == clc_pkg::CLC_FF_D) ? cell_val :
                (ff_type == clc_pkg::CLC_FF_T) ? (q_r ^ cell_val) :
                (ff_type == clc_pkg::CLC_FF_JK) ? ((cell_val & ~q_r) | (~k_in & q_r)) :
                (cell_val | (~k_in & q_r));
  // Clear gate after load mux, both after cascade
  wire load_mux = grp_sload ? grp_sload_data : ff_val;
  wire sync_val = ~grp_sclr & load_mux;

  // Asynchronous controls per scheme; only clear is native
  wire preset_scheme = (ctl == clc_pkg::CLC_CTL_PRE) || (ctl == clc_pkg::CLC_CTL_PRE_CLR) ||
                       (ctl == clc_pkg::CLC_CTL_PRE_LOAD);
  wire load_scheme = (ctl == clc_pkg::CLC_CTL_ALOAD) || (ctl == clc_pkg::CLC_CTL_PRE_LOAD);
  wire a_clear = aclr && (ctl != clc_pkg::CLC_CTL_PRE) && (ctl != clc_pkg::CLC_CTL_PRE_LOAD);
  wire a_preset = preset_scheme && (ctl == clc_pkg::CLC_CTL_PRE ? aclr : grp_apreset);
  wire a_load = load_scheme && grp_aload;
  wire gclr = GCLR_EN && !global_register_clear_n;
  wire gclr_val = preset_scheme && (ctl != clc_pkg::CLC_CTL_PRE_LOAD);
  assign cells_used_emul = (ctl != clc_pkg::CLC_CTL_CLR);
  wire [2:0] cells_used = cells_used_emul ? clc_pkg::CLC_COST_EMUL : clc_pkg::CLC_COST_NATIVE;
  // Synchronous path is taken at this edge
  wire sync_go = !gclr && !a_clear && !a_preset && !a_load && tick && grp_ena;

  always_comb begin
    q_nxt = q_r;
    unknown_nxt = q_unknown_r;
    if (gclr) begin
      q_nxt = gclr_val;
      unknown_nxt = (ctl == clc_pkg::CLC_CTL_PRE_LOAD);
    end else if (a_clear) begin
      q_nxt = 1'b0;
      unknown_nxt = 1'b0;
    end else if (a_preset) begin
      q_nxt = 1'b1;
      unknown_nxt = 1'b0;
    end else if (a_load) begin
      q_nxt = grp_aload_data;
      unknown_nxt = 1'b0;
    end else if (tick && grp_ena) begin
      q_nxt = sync_val;
      unknown_nxt = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q_r <= 1'b0;
      q_unknown_r <= 1'b0;
    end else begin
      q_r <= q_nxt;
      q_unknown_r <= unknown_nxt;
    end
  end

  // Outputs: bypass forces lookup result; arithmetic can show both at once
  wire comb_val = cell_val;
  assign out_a = (outa_reg && !bypass) ? q_r : comb_val;
  assign out_b = (outb_reg && !bypass) ? q_r : comb_val;

  // AHB-Lite slave, zero wait states
  wire [1:0] ht = htrans;
  wire addr_ph = hsel && hready &&
    ((ht == clc_pkg::CLC_HTRANS_NONSEQ) || (ht == clc_pkg::CLC_HTRANS_SEQ));
  wire [7:0] a8 = haddr[7:0];
  wire hit_cfg = (a8 == clc_pkg::CLC_CFG_OFF);
  wire hit_lut = (a8 == clc_pkg::CLC_LUT_OFF);
  wire hit_stat = (a8 == clc_pkg::CLC_STAT_OFF);
  wire [31:0] stat_word = {21'h00_0000, cells_used, q_unknown_r, cascade_out,
                           carry_hop_out, carry_out, out_b, out_a, q_r, lut_res};
  wire [31:0] rd_word = hit_cfg ? cfg_r :
                        hit_lut ? {16'h0000, lut_r} :
                        hit_stat ? stat_word : 32'h0000_0000;
  wire wr_cfg = wr_pend_r && (wr_addr_r == clc_pkg::CLC_CFG_OFF);
  wire wr_lut = wr_pend_r && (wr_addr_r == clc_pkg::CLC_LUT_OFF);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
    end else begin
      wr_pend_r <= addr_ph && hwrite;
      wr_addr_r <= a8;
      hrdata_r <= (addr_ph && !hwrite) ? rd_word : hrdata_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_r <= clc_pkg::CLC_CFG_RST;
      lut_r <= clc_pkg::CLC_LUT_RST;
    end else begin
      cfg_r <= wr_cfg ? {10'h000, hwdata[21:0]} : cfg_r;
      lut_r <= wr_lut ? hwdata[15:0] : lut_r;
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp = clc_pkg::CLC_HRESP_OKAY;

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_sclr_over_load: assert property (
    (!gclr && !a_clear && !a_preset && !a_load && tick && grp_ena && grp_sclr && grp_sload)
      |=> !q_r)
    else $error("sync clear lost to sync load");
  a_sload_over_casc: assert property (
    (!gclr && !a_clear && !a_preset && !a_load && tick && grp_ena && !grp_sclr && grp_sload
      && casc_en) |=> (q_r == $past(grp_sload_data)))
    else $error("sync load lost to cascade");
  a_gclr_priority: assert property (
    (gclr && !preset_scheme) |=> !q_r)
    else $error("chip clear did not clear register");
  a_gclr_preset: assert property (
    (gclr && gclr_val) |=> q_r)
    else $error("emulated preset register not preset on chip clear");
  a_unknown_flag: assert property (
    (gclr && ctl == clc_pkg::CLC_CTL_PRE_LOAD) |=> q_unknown_r)
    else $error("preset-load register not flagged unknown");
  a_enable_gates: assert property (
    (!gclr && !a_clear && !a_preset && !a_load && !grp_ena) |=> $stable(q_r))
    else $error("register changed without enable");
  a_bypass_out: assert property (
    bypass |-> (out_a == cell_val && out_b == cell_val))
    else $error("bypass did not route lookup result");
  a_arith_both: assert property (
    (is_arith && outa_reg && !outb_reg && !bypass) |-> (out_a == q_r && out_b == comb_val))
    else $error("arithmetic outputs not registered and raw");
  a_carry_hop: assert property (
    last_in_group |-> (!carry_out && carry_hop_out == carry_gen))
    else $error("group carry not handed over");
  a_ahb_okay: assert property (
    addr_ph && !hwrite |=> hreadyout && hresp == clc_pkg::CLC_HRESP_OKAY && hrdata == $past(rd_word))
    else $error("read data not presented in data phase");

  // Storage element per type
  a_d_capture: assert property (
    (sync_go && !grp_sclr && !grp_sload && ff_type == clc_pkg::CLC_FF_D)
      |=> (q_r == $past(cell_val)))
    else $error("D register did not capture");
  a_t_toggle: assert property (
    (sync_go && !grp_sclr && !grp_sload && ff_type == clc_pkg::CLC_FF_T)
      |=> (q_r == ($past(q_r) ^ $past(cell_val))))
    else $error("T register did not toggle");
  a_jk_update: assert property (
    (sync_go && !grp_sclr && !grp_sload && ff_type == clc_pkg::CLC_FF_JK)
      |=> (q_r == (($past(cell_val) && !$past(q_r)) || (!$past(k_in) && $past(q_r)))))
    else $error("JK register update wrong");
  a_sr_update: assert property (
    (sync_go && !grp_sclr && !grp_sload && ff_type == clc_pkg::CLC_FF_SR)
      |=> (q_r == ($past(cell_val) || (!$past(k_in) && $past(q_r)))))
    else $error("SR register update wrong");

  // Source selection
  a_tick_off: assert property (
    (clk_src == clc_pkg::CLC_SRC_OFF) |-> !tick)
    else $error("cell clock active with source off");
  a_clr_off: assert property (
    (clr_src == clc_pkg::CLC_SRC_OFF) |-> !aclr)
    else $error("clear active with source off");
  a_tick_pin: assert property (
    (clk_src == clc_pkg::CLC_SRC_PIN) |-> (tick == tick_pin))
    else $error("pin clock source not selected");
  a_clr_internal: assert property (
    (clr_src == clc_pkg::CLC_SRC_INTERNAL) |-> (aclr == clr_internal))
    else $error("internal clear source not selected");

  // Mode and input routing
  a_one_mode: assert property (
    $onehot({is_norm, is_arith, is_cnt}))
    else $error("not exactly one mode active");
  a_rsvd_normal: assert property (
    (mode_raw == clc_pkg::CLC_MODE_RSVD) |-> is_norm)
    else $error("reserved mode code not run as normal");
  a_norm_index: assert property (
    is_norm |-> (lut_res == lut_r[data_in]))
    else $error("normal lookup not indexed by data inputs");
  a_arith_index: assert property (
    is_arith
      |-> (lut_res == lut_r[{1'b0, data_in[0], data_in[1], carry_in}]))
    else $error("arithmetic sum not indexed by operands and carry");
  a_cnt_feedback: assert property (
    is_cnt
      |-> (lut_res == lut_r[{1'b0, q_r, data_in[0], carry_in}]))
    else $error("count table not fed by register");

  // Carry and cascade chains
  a_carry_pass: assert property (
    (is_norm && !last_in_group) |-> (carry_out == carry_in))
    else $error("carry not passed through normal cell");
  a_carry_gen: assert property (
    (!is_norm && !last_in_group)
      |-> (carry_out == lut_r[{1'b1, op_a, op_b, carry_in}]))
    else $error("carry not taken from carry table");
  a_no_hop: assert property (
    !last_in_group |-> !carry_hop_out)
    else $error("group hop before last cell");
  a_final_cell: assert property (
    (final_cell && !casc_en) |-> (cascade_out == carry_in))
    else $error("final cell did not route carry");
  a_casc_off: assert property (
    !casc_en |-> (cascade_out == cell_val_raw))
    else $error("cascade combined while disabled");
  a_casc_and: assert property (
    (casc_en && !casc_or)
      |-> (cascade_out == (cascade_in && cell_val_raw)))
    else $error("cascade AND wrong");
  a_casc_or: assert property (
    (casc_en && casc_or)
      |-> (cascade_out == (cascade_in || cell_val_raw)))
    else $error("cascade OR wrong");

  // Output selection
  a_out_swap: assert property (
    (!outa_reg && outb_reg && !bypass) |-> (out_a == cell_val && out_b == q_r))
    else $error("outputs not independently selected");
  a_plain_adder: assert property (
    (is_arith && !outb_reg) |-> (out_b == cell_val))
    else $error("plain adder output registered");

  // Control priority and emulated schemes
  a_sclr_over_casc: assert property (
    (sync_go && grp_sclr && casc_en) |=> !q_r)
    else $error("sync clear lost to cascade");
  a_tick_gates: assert property (
    (!gclr && !a_clear && !a_preset && !a_load && !tick) |=> $stable(q_r))
    else $error("register changed without cell clock");
  a_native_clear: assert property (
    (!gclr && a_clear) |=> !q_r)
    else $error("asynchronous clear ignored");
  a_emul_preset: assert property (
    (!gclr && !a_clear && a_preset) |=> q_r)
    else $error("emulated preset ignored");
  a_emul_load: assert property (
    (!gclr && !a_clear && !a_preset && a_load)
      |=> (q_r == $past(grp_aload_data)))
    else $error("emulated load ignored");
  a_flag_cleared: assert property (
    (!gclr && (a_clear || a_preset || a_load || sync_go))
      |=> !q_unknown_r)
    else $error("unknown flag kept after register update");
  a_emul_cost: assert property (
    (ctl != clc_pkg::CLC_CTL_CLR) |-> (cells_used == clc_pkg::CLC_COST_EMUL))
    else $error("emulated scheme cost not reported");

  c_counter_tick: cover property (is_cnt && tick && grp_ena && !grp_sclr);
  c_accumulate: cover property (is_arith && tick && grp_ena && outa_reg);
  c_cascade_or: cover property (casc_en && casc_or && cascade_in);
  c_gclr_preset: cover property (gclr && gclr_val);
  c_bypass_tick: cover property (bypass && tick && grp_ena);

endmodule // clc_cell

// [tb/clc_neighbour.sv]
// Purpose: Lower-order neighbour cell feeding the carry and cascade chains
// Assumes: Neighbour logic shares the cell clock
// Notes: Chain values launch one clock after they are set
`timescale 1ns/10ps
module clc_neighbour (
  input wire logic hclk,
  input wire logic carry_set,
  input wire logic casc_set,
  output logic carry_in,
  output logic cascade_in
);
  always @(posedge hclk) begin
    carry_in <= carry_set;
    cascade_in <= casc_set;
  end
endmodule // clc_neighbour

// [tb/configurable_logic_cell_bench.sv]
// Purpose: Self-checking bench for the configurable logic cell
// Assumes: Zero-wait register bus; neighbour model drives the chains
// Notes: Cell clock events are single grp_ena pulses with tick held high
`timescale 1ns/10ps
module configurable_logic_cell_bench;
  localparam logic [15:0] PAT = 16'h6C3A;
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hreadyout, hresp, carry_in, cascade_in, carry_set, casc_set;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] data_in;
  logic tick_global, tick_pin, clr_global, clr_pin, grp_sclr, grp_sload, grp_sload_data, grp_ena;
  logic global_register_clear_n, out_a, out_b, carry_out, carry_hop_out, cascade_out;
  logic grp_apreset, grp_aload, grp_aload_data;
  logic cells_used_emul;
  int checks = 0;
  int error_cnt = 0;
  always #2.5 hclk = ~hclk;
  clc_cell u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .data_in, .carry_in, .cascade_in,
    .tick_global, .tick_pin, .tick_internal(1'b0), .clr_global, .clr_pin, .clr_internal(1'b0),
    .grp_apreset, .grp_aload, .grp_aload_data, .grp_sclr, .grp_sload,
    .grp_sload_data, .grp_ena, .global_register_clear_n, .out_a, .out_b, .carry_out,
    .carry_hop_out, .cascade_out, .cells_used_emul);
  clc_neighbour u_nb (.hclk, .carry_set, .casc_set, .carry_in, .cascade_in);
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= clc_pkg::CLC_HTRANS_NONSEQ;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rv = hrdata;
  endtask
  function automatic logic [31:0] cf(logic [1:0] m, logic [1:0] f, logic [3:0] p,
                                     logic [2:0] c, logic [1:0] cs);
    return 32'(m) << clc_pkg::CLC_F_MODE | 32'(f) << clc_pkg::CLC_F_FF
      | 32'h1 << clc_pkg::CLC_F_OUTA | 32'(cs) << clc_pkg::CLC_F_CASC_EN
      | 32'(p) << clc_pkg::CLC_F_POS | 32'(c) << clc_pkg::CLC_F_CTL;
  endfunction
  // One cell clock event, checked two edges later
  task automatic ev;
    @(posedge hclk);
    grp_ena <= 1'b1;
    @(posedge hclk);
    grp_ena <= 1'b0;
    @(posedge hclk);
  endtask
  task automatic t_regs;
    bus(1'b0, clc_pkg::CLC_CFG_OFF, 32'h0);
    chk("cfg reset", rv, clc_pkg::CLC_CFG_RST);
    chk("okay ready", {30'h0, hreadyout, hresp}, 32'h2);
    bus(1'b1, 8'h0C, 32'hFFFF_FFFF);
    bus(1'b0, 8'h0C, 32'h0);
    chk("unmapped", rv, 32'h0);
    bus(1'b1, clc_pkg::CLC_CFG_OFF, 32'hFFFF_FFFF);
    bus(1'b0, clc_pkg::CLC_CFG_OFF, 32'h0);
    chk("cfg bits", rv, 32'h003F_FFFF);
    bus(1'b1, clc_pkg::CLC_LUT_OFF, 32'hFFFF_FFFF);
    bus(1'b0, clc_pkg::CLC_LUT_OFF, 32'h0);
    chk("lut bits", rv, 32'h0000_FFFF);
  endtask
  task automatic t_lookup;
    bus(1'b1, clc_pkg::CLC_CFG_OFF, cf(clc_pkg::CLC_NORMAL, 2'h0, 4'h1, 3'h0, 2'h0));
    bus(1'b1, clc_pkg::CLC_LUT_OFF, {16'h0, PAT});
    for (int i = 0; i < 16; i++) begin
      data_in <= 4'(i);
      @(posedge hclk);
      chk("out_b lookup", out_b, {31'h0, PAT[i]});
    end
  endtask
  task automatic t_store;
    bus(1'b1, clc_pkg::CLC_CFG_OFF, cf(clc_pkg::CLC_NORMAL, 2'h0, 4'h1, 3'h0, 2'h0));
    bus(1'b1, clc_pkg::CLC_LUT_OFF, 32'h2);
    data_in <= 4'h1;
    tick_global <= 1'b1;
    repeat (3) @(posedge hclk);
    chk("q no enable", out_a, 32'h0);
    chk("out_b raw", out_b, 32'h1);
    ev();
    chk("q d type", out_a, 32'h1);
    bus(1'b1, clc_pkg::CLC_CFG_OFF, cf(clc_pkg::CLC_NORMAL, 2'h0, 4'h1, 3'h0, 2'h0) | 32'h200);
    data_in <= 4'h0;
    ev();
    chk("q pin idle", out_a, 32'h1);
    tick_pin <= 1'b1;
    ev();
    chk("q pin tick", out_a, 32'h0);
    tick_pin <= 1'b0;
    bus(1'b1, clc_pkg::CLC_CFG_OFF, cf(clc_pkg::CLC_NORMAL, 2'h1, 4'h1, 3'h0, 2'h0));
    data_in <= 4'h1;
    ev();
    chk("q t set", out_a, 32'h1);
    ev();
    chk("q t clr", out_a, 32'h0);
  endtask
  task automatic t_sync;
    bus(1'b1, clc_pkg::CLC_CFG_OFF, cf(clc_pkg::CLC_NORMAL, 2'h0, 4'h1, 3'h0, 2'h0) | 32'h800);
    data_in <= 4'h0;
    grp_sclr <= 1'b1;
    grp_sload <= 1'b1;
    grp_sload_data <= 1'b1;
    ev();
    chk("q clr over load", out_a, 32'h0);
    grp_sclr <= 1'b0;
    ev();
    chk("q sload", out_a, 32'h1);
    grp_sclr <= 1'b1;
    grp_sload <= 1'b0;
    clr_global <= 1'b1;
    repeat (3) @(posedge hclk);
    chk("q sclr no enable", out_a, 32'h1);
    clr_pin <= 1'b1;
    repeat (3) @(posedge hclk);
    chk("q async clr", out_a, 32'h0);
    clr_pin <= 1'b0;
    clr_global <= 1'b0;
    grp_sclr <= 1'b0;
  endtask
  task automatic t_clear;
    grp_sload <= 1'b1;
    ev();
    global_register_clear_n <= 1'b0;
    ev();
    chk("q chip clear", out_a, 32'h0);
    global_register_clear_n <= 1'b1;
    bus(1'b1, clc_pkg::CLC_CFG_OFF, cf(clc_pkg::CLC_NORMAL, 2'h0, 4'h1, 3'h1, 2'h0));
    @(posedge hclk);
    chk("emulated flag", cells_used_emul, 32'h1);
    bus(1'b0, clc_pkg::CLC_STAT_OFF, 32'h0);
    chk("cells used", rv & 32'h700, 32'h400);
    global_register_clear_n <= 1'b0;
    repeat (3) @(posedge hclk);
    chk("q chip preset", out_a, 32'h1);
    global_register_clear_n <= 1'b1;
    grp_sload <= 1'b0;
  endtask
  task automatic t_arith;
    logic [2:0] v;
    bus(1'b1, clc_pkg::CLC_CFG_OFF, cf(clc_pkg::CLC_ARITH, 2'h0, 4'h1, 3'h0, 2'h0));
    bus(1'b1, clc_pkg::CLC_LUT_OFF, 32'hE896);
    for (int i = 0; i < 8; i++) begin
      v = 3'(i);
      data_in <= {2'h0, v[1], v[2]};
      carry_set <= v[0];
      ev();
      chk("sum raw", out_b, {31'h0, ^v});
      chk("sum held", out_a, {31'h0, ^v});
      chk("carry", carry_out, {31'h0, v[2] & v[1] | v[2] & v[0] | v[1] & v[0]});
      chk("no hop", carry_hop_out, 32'h0);
    end
    bus(1'b1, clc_pkg::CLC_CFG_OFF, cf(clc_pkg::CLC_ARITH, 2'h0, 4'hA, 3'h0, 2'h0));
    data_in <= 4'h3;
    carry_set <= 1'b1;
    repeat (3) @(posedge hclk);
    chk("carry at last", carry_out, 32'h0);
    chk("carry hop", carry_hop_out, 32'h1);
  endtask
  task automatic t_casc;
    bus(1'b1, clc_pkg::CLC_CFG_OFF, cf(clc_pkg::CLC_NORMAL, 2'h0, 4'h1, 3'h0, 2'h1));
    bus(1'b1, clc_pkg::CLC_LUT_OFF, 32'h2);
    data_in <= 4'h1;
    casc_set <= 1'b0;
    repeat (3) @(posedge hclk);
    chk("cascade and low", cascade_out, 32'h0);
    casc_set <= 1'b1;
    repeat (3) @(posedge hclk);
    chk("cascade and high", cascade_out, 32'h1);
    bus(1'b1, clc_pkg::CLC_CFG_OFF, cf(clc_pkg::CLC_NORMAL, 2'h0, 4'h1, 3'h0, 2'h3));
    data_in <= 4'h0;
    repeat (3) @(posedge hclk);
    chk("cascade or", cascade_out, 32'h1);
  endtask
  task automatic t_count;
    bus(1'b1, clc_pkg::CLC_CFG_OFF, cf(clc_pkg::CLC_COUNTER, 2'h0, 4'h1, 3'h0, 2'h1));
    bus(1'b1, clc_pkg::CLC_LUT_OFF, 32'hA05A);
    {carry_set, casc_set, grp_sclr} <= 3'h7;
    ev();
    chk("count clear", out_a, 32'h0);
    grp_sclr <= 1'b0;
    ev();
    chk("count up", out_a, 32'h1);
    chk("count carry", carry_out, 32'h1);
    ev();
    chk("count wrap", out_a, 32'h0);
    {casc_set, grp_sload, grp_sload_data} <= 3'h3;
    ev();
    chk("load over cascade", out_a, 32'h1);
    grp_sload <= 1'b0;
    bus(1'b1, clc_pkg::CLC_CFG_OFF, cf(clc_pkg::CLC_COUNTER, 2'h0, 4'h1, 3'h0, 2'h0) | 32'h10);
    @(posedge hclk);
    chk("bypass lookup", out_a, 32'h0);
  endtask
  task automatic t_emul;
    bus(1'b1, clc_pkg::CLC_CFG_OFF, cf(clc_pkg::CLC_NORMAL, 2'h2, 4'h1, 3'h4, 2'h0));
    global_register_clear_n <= 1'b0;
    @(posedge hclk);
    global_register_clear_n <= 1'b1;
    bus(1'b0, clc_pkg::CLC_STAT_OFF, 32'h0);
    chk("unknown flag", rv & 32'h80, 32'h80);
    {grp_aload, grp_aload_data, data_in} <= 6'h30;
    repeat (2) @(posedge hclk);
    chk("async load", out_a, 32'h1);
    grp_aload <= 1'b0;
    ev();
    chk("jk hold", out_a, 32'h1);
    data_in <= 4'h8;
    ev();
    chk("jk reset", out_a, 32'h0);
    bus(1'b1, clc_pkg::CLC_CFG_OFF, cf(clc_pkg::CLC_NORMAL, 2'h0, 4'h1, 3'h2, 2'h0) ^ 32'h60);
    grp_apreset <= 1'b1;
    repeat (2) @(posedge hclk);
    chk("preset on out_b", out_b, 32'h1);
    chk("lookup on out_a", out_a, 32'h0);
    grp_apreset <= 1'b0;
  endtask
  task automatic wrap_up;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Whole run needs well under a thousand cycles
  initial begin
    #100000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    {hresetn, hsel, hwrite, haddr, hwdata, htrans, data_in, carry_set, casc_set} = '0;
    {tick_global, tick_pin, clr_global, clr_pin, grp_sclr, grp_sload} = '0;
    {grp_sload_data, grp_ena, grp_apreset, grp_aload, grp_aload_data} = '0;
    hsize = 3'h2;
    global_register_clear_n = 1'b1;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_lookup();
    t_store();
    t_sync();
    t_clear();
    t_arith();
    t_casc();
    t_count();
    t_emul();
    wrap_up();
  end
endmodule // configurable_logic_cell_bench
